// *** dv/dbs_bus_asserts.sv ***
`timescale 1ns/1ps
module dbs_bus_asserts import dbs_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_cycle_n,
    input wire logic read_write,
    input wire logic [LANES-1:0] byte_write_enable_n,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_inverted,
    input wire logic read_valid_flag
);
    // ==========================================================
    // Link checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    clock_pair_a: assert property (k_n == !k && ($past(srst) || k != $past(k)))
        else $error("inverted clock not in antiphase");
    echo_follow_a: assert property (!$past(srst) |->
        echo_clock == $past(k) && echo_clock_inverted == !echo_clock)
        else $error("echo clocks not following main clock");
    load_rise_a: assert property (!load_cycle_n |-> k && !$past(k))
        else $error("load outside main clock rise");
    load_gap_a: assert property (!load_cycle_n |=> load_cycle_n [*7])
        else $error("load during burst");
    rd_valid_a: assert property (!load_cycle_n && read_write |->
        ##4 read_valid_flag [*4] ##1 !read_valid_flag)
        else $error("read valid window wrong");
    rd_data_a: assert property (!load_cycle_n && read_write |->
        ##5 dev_dq_oe [*4] ##1 !dev_dq_oe)
        else $error("read data window wrong");
    valid_lead_a: assert property ($rose(read_valid_flag) |=> $rose(dev_dq_oe))
        else $error("valid does not lead data");
    valid_tail_a: assert property ($fell(read_valid_flag) |-> dev_dq_oe ##1 !dev_dq_oe)
        else $error("valid does not end before data");
    wr_data_a: assert property (!load_cycle_n && !read_write |->
        ##2 host_dq_oe [*4] ##1 !host_dq_oe)
        else $error("write data window wrong");
    be_idle_a: assert property (!host_dq_oe |-> byte_write_enable_n == BE_NONE_N)
        else $error("byte enables active outside write beats");
    no_clash_a: assert property (!(dev_dq_oe && host_dq_oe))
        else $error("both ends drive data bus");

    cover property (!load_cycle_n && read_write);
    cover property (!load_cycle_n && !read_write);
    cover property (host_dq_oe && byte_write_enable_n == 2'h2);
    cover property (!load_cycle_n && !read_write ##8 !load_cycle_n);
endmodule : dbs_bus_asserts

// *** dv/ddr_burst_sram_bus_port_tb.sv ***
`timescale 1ns/1ps
module ddr_burst_sram_bus_port_tb import dbs_pkg::*;;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] base;
        logic [LANES-1:0] be_n;
    } dbs_row_t;
    logic clk, srst, cmd_valid, cmd_ready, cmd_write, wr_valid, wr_ready, rd_valid;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [LANES-1:0] wr_byte_en_n;
    logic bypass_req_n, term_sel_req, term_float_req, host_ready;
    logic loop_locked, odt_enable, odt_high_range, burst_busy;
    logic [DATA_W-1:0] mem [256];
    int num_errors = 0;
    int samples_checked = 0;
    // Rows touch only words written whole beforehand; unwritten words read unknown
    dbs_row_t rows [5] = '{'{21'h000010, 18'h00100, 2'h0}, '{21'h000010, 18'h2aa00, 2'h2},
        '{21'h000013, 18'h15501, 2'h1}, '{21'h1ffffc, 18'h3fff0, 2'h0},
        '{21'h000101, 18'h01230, 2'h0}};

    dbs_if bus_if ();
    dbs_device u_dbs_device (.clk(clk), .srst(srst), .bus(bus_if), .loop_locked(loop_locked),
        .odt_enable(odt_enable), .odt_high_range(odt_high_range), .burst_busy(burst_busy));
    dbs_host u_dbs_host (.clk(clk), .srst(srst), .bus(bus_if), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .wr_byte_en_n(wr_byte_en_n), .rd_valid(rd_valid), .rd_data(rd_data),
        .bypass_req_n(bypass_req_n), .term_sel_req(term_sel_req),
        .term_float_req(term_float_req), .host_ready(host_ready));
    dbs_bus_asserts u_dbs_bus_asserts (.clk(clk), .srst(srst), .k(bus_if.k), .k_n(bus_if.k_n),
        .load_cycle_n(bus_if.load_cycle_n), .read_write(bus_if.read_write),
        .byte_write_enable_n(bus_if.byte_write_enable_n), .host_dq_oe(bus_if.host_dq_oe),
        .dev_dq_oe(bus_if.dev_dq_oe), .echo_clock(bus_if.echo_clock),
        .echo_clock_inverted(bus_if.echo_clock_inverted),
        .read_valid_flag(bus_if.read_valid_flag));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic hang(input string what);
        num_errors++;
        $display("wrong value %s expected done seen timeout", what);
        final_report();
    endtask : hang

    task automatic wait_ready();
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while ((host_ready !== 1'b1 || loop_locked !== 1'b1) && t < 6000);
        if (t >= 6000) hang("host_ready");
    endtask : wait_ready

    // Looks at both ends while reset still holds, then releases it on a rising edge
    task automatic reset_checks();
        @(negedge clk);
        check("dev_dq_oe", DATA_W'(bus_if.dev_dq_oe), '0);
        check("valid_flag", DATA_W'(bus_if.read_valid_flag), '0);
        check("be_n", DATA_W'(bus_if.byte_write_enable_n), DATA_W'(BE_NONE_N));
        check("load_n", DATA_W'(bus_if.load_cycle_n), 18'h1);
        check("locked_reset", DATA_W'(loop_locked), '0);
        @(posedge clk);
        srst <= 1'b0;
    endtask : reset_checks

    // Valid stays high across words so no edge sees it lowered and raised
    task automatic push(input int n, input logic [DATA_W-1:0] base, input logic [LANES-1:0] be);
        int t;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_byte_en_n <= be;
        for (int i = 0; i < n; i++) begin
            wr_data <= base + DATA_W'(i);
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (wr_ready !== 1'b1 && t < 50);
            if (t >= 50) hang("wr_ready");
            @(posedge clk);
        end
        wr_valid <= 1'b0;
    endtask : push

    task automatic cmd(input logic wr, input logic [ADDR_W-1:0] a);
        int t;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (cmd_ready !== 1'b1 && t < 100);
        if (t >= 100) hang("cmd_ready");
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : cmd

    task automatic model(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] base,
        input logic [LANES-1:0] be);
        logic [DATA_W-1:0] d;
        for (int i = 0; i < BURST_LEN; i++) begin
            d = base + DATA_W'(i);
            for (int l = 0; l < LANES; l++) begin
                if (!be[l]) mem[{a[7:2], 2'(i)}][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
            end
        end
    endtask : model

    task automatic do_read(input logic [ADDR_W-1:0] a);
        int n, t, clash;
        cmd(1'b0, a);
        n = 0;
        t = 0;
        clash = 0;
        while (n < BURST_LEN && t < 40) begin
            @(negedge clk);
            t++;
            if (odt_enable === 1'b1 && bus_if.dev_dq_oe === 1'b1) clash++;
            if (rd_valid === 1'b1) begin
                check("rd_data", rd_data, mem[{a[7:2], 2'(n)}]);
                check("busy", DATA_W'(burst_busy), DATA_W'(n < BURST_LEN - 1));
                n++;
            end
        end
        if (n < BURST_LEN) hang("rd_valid");
        check("odt_clash", DATA_W'(clash), '0);
    endtask : do_read

    // ==========================================================
    // Sequence
    initial begin
        srst = 1'b1;
        {cmd_valid, cmd_write, wr_valid, term_sel_req, term_float_req} = '0;
        cmd_addr = '0;
        wr_data = '0;
        wr_byte_en_n = BE_NONE_N;
        bypass_req_n = 1'b1;
        repeat (15) @(posedge clk);
        reset_checks();
        wait_ready();
        $display("test reset done");
        foreach (rows[r]) begin
            push(BURST_LEN, rows[r].base, rows[r].be_n);
            cmd(1'b1, rows[r].addr);
            model(rows[r].addr, rows[r].base, rows[r].be_n);
            do_read(rows[r].addr);
        end
        $display("test rows done");
        push(FIFO_DEPTH, 18'h00400, 2'h0);
        @(negedge clk);
        check("wr_ready_full", DATA_W'(wr_ready), '0);
        cmd(1'b1, 21'h000040);
        cmd(1'b1, 21'h000044);
        model(21'h000040, 18'h00400, 2'h0);
        model(21'h000044, 18'h00404, 2'h0);
        do_read(21'h000040);
        do_read(21'h000044);
        check("wr_ready_empty", DATA_W'(wr_ready), 18'h1);
        $display("test fifo done");
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            term_sel_req <= (m == 1);
            term_float_req <= (m == 2);
            repeat (4) @(posedge clk);
            @(negedge clk);
            check("odt_high", DATA_W'(odt_high_range), DATA_W'(m != 0));
            check("odt_idle", DATA_W'(odt_enable), 18'h1);
        end
        $display("test termination done");
        @(posedge clk);
        bypass_req_n <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("locked_bypass", DATA_W'(loop_locked), 18'h1);
        wait_ready();
        do_read(21'h000010);
        $display("test bypass done");
        // Reset in mid-run; the array keeps its words, so a read still matches
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        reset_checks();
        wait_ready();
        do_read(21'h1ffffc);
        $display("test mid reset done");
        final_report();
    end
endmodule : ddr_burst_sram_bus_port_tb

// *** verilog/dbs_device.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Address taken only at main clock rise
// - Every transaction moves four words, two periods
// - Older generation: low address bits pick start
// - Address ignored when deselected or burst busy
// - Controller drives load low to start cycle
// - Direction high means read, low means write
// - Only lanes with enable low get stored
// - Byte enables sampled with their data word
// - Control on main rise, data both rises
// - Controller keeps clocks toggling in antiphase
// - Bypass low skips delay loop setup wait (device only; controller still waits LOOP_SETUP_CYC before host_ready)
// - Termination select picks range or disables
// - Read data launched from main clock pair
// - Echo clocks toggle always, matched to data
// - Valid flag leads data by half cycle
// - Termination on while receiving, off driving
module dbs_device import dbs_pkg::*; #(
    parameter bit LEGACY_GEN = 1'b0,
    parameter bit HAS_TERM = 1'b1,
    parameter bit TERM_OPTION2 = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    dbs_if.device bus,
    output logic loop_locked,
    output logic odt_enable,
    output logic odt_high_range,
    output logic burst_busy
);

    typedef struct packed {
        dbs_dev_state_t state;
        logic k_d;
        logic [CNT_W-1:0] cnt;
        logic rd;
        logic [ADDR_W-1:0] base;
        logic [1:0] start;
        logic byp_d;
        logic [LOCK_W-1:0] lock_cnt;
        logic locked;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic valid;
        logic cq;
        logic cq_n;
        logic odt_on;
        logic odt_hi;
    } dbs_dev_st_t;

    dbs_dev_st_t s;
    dbs_dev_st_t next_s;
    logic [DATA_W-1:0] mem [2**MEM_AW];

    logic k_rise;
    logic accept;
    logic wr_beat;
    logic fetch;
    logic [1:0] fetch_beat;
    logic [CNT_W-1:0] wait_last;
    logic term_on;
    logic term_hi;

    // ==========================================================
    // Burst addressing
    // Wrap inside the aligned group of four, starting at the chosen word
    function automatic logic [MEM_AW-1:0] word_addr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0] start,
        input logic [1:0] beat
    );
        logic [1:0] idx;
        idx = start + beat;
        word_addr = {base[MEM_AW-1:2], idx};
    endfunction : word_addr

    // ==========================================================
    // Command sampling
    // Main clock rise is seen as the first beat with k high
    assign k_rise = bus.k && !s.k_d;
    assign accept = k_rise && !bus.load_cycle_n && s.state == DEV_IDLE && s.locked;
    assign wait_last = s.rd ? RD_WAIT_LAST : WR_WAIT_LAST;
    assign wr_beat = s.state == DEV_XFER && !s.rd;

    // ==========================================================
    // Termination mode
    always_comb begin
        term_on = 1'b0;
        term_hi = 1'b0;
        if (HAS_TERM) begin
            if (bus.termination_float) begin
                term_on = !TERM_OPTION2;
                term_hi = !TERM_OPTION2;
            end else if (bus.termination_select) begin
                term_on = 1'b1;
                term_hi = 1'b1;
            end else begin
                term_on = !TERM_OPTION2;
                term_hi = 1'b0;
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        next_s = s;
        fetch = 1'b0;
        fetch_beat = 2'h0;
        next_s.k_d = bus.k;
        // Echo clocks follow k with the same one-flop delay as read data
        next_s.cq = bus.k;
        next_s.cq_n = bus.k_n;
        next_s.byp_d = bus.loop_bypass_n;

        // Delay loop lock; a level change restarts the setup wait
        if (bus.loop_bypass_n != s.byp_d) begin
            next_s.locked = 1'b0;
            next_s.lock_cnt = '0;
        end else if (!bus.loop_bypass_n) begin
            next_s.locked = 1'b1;
        end else if (!s.locked) begin
            if (s.lock_cnt == LOOP_SETUP_CYC - 1'b1) begin
                next_s.locked = 1'b1;
            end else begin
                next_s.lock_cnt = s.lock_cnt + 1'b1;
            end
        end

        case (s.state)
            DEV_IDLE: begin
                if (accept) begin
                    next_s.base = bus.address_inputs;
                    next_s.start = LEGACY_GEN ? bus.address_inputs[1:0] : 2'h0;
                    next_s.rd = bus.read_write;
                    next_s.cnt = '0;
                    next_s.state = DEV_WAIT;
                end
            end
            DEV_WAIT: begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.rd && s.cnt == wait_last) begin
                    fetch = 1'b1;
                    fetch_beat = 2'h0;
                end
                if (s.cnt == wait_last) begin
                    next_s.cnt = '0;
                    next_s.state = DEV_XFER;
                end
            end
            DEV_XFER: begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.rd && s.cnt != BEAT_LAST) begin
                    fetch = 1'b1;
                    fetch_beat = s.cnt[1:0] + 2'h1;
                end
                if (s.cnt == BEAT_LAST) begin
                    next_s.state = DEV_IDLE;
                end
            end
            default: begin
                next_s.state = DEV_IDLE;
            end
        endcase

        // Launch on the beat edges of the main clock pair
        next_s.dq_oe = fetch;
        if (fetch) begin
            next_s.dq = mem[word_addr(s.base, s.start, fetch_beat)];
        end

        // Flag rises one beat before the first word and falls one before the end
        next_s.valid = s.rd && ((s.state == DEV_WAIT && s.cnt >= wait_last - 1'b1)
            || (s.state == DEV_XFER && s.cnt < VALID_LAST + 1'b1));

        // Termination only while the device is not driving
        next_s.odt_on = term_on && !next_s.dq_oe;
        next_s.odt_hi = term_hi;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Write lanes
    // Lane enable is taken in the same beat as its data word
    always_ff @(posedge clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (wr_beat && !bus.byte_write_enable_n[l]) begin
                mem[word_addr(s.base, s.start, s.cnt[1:0])][l*LANE_W +: LANE_W]
                    <= bus.dq[l*LANE_W +: LANE_W];
            end
        end
    end

    // ==========================================================
    // Outputs
    assign bus.dev_dq = s.dq;
    assign bus.dev_dq_oe = s.dq_oe;
    assign bus.echo_clock = s.cq;
    assign bus.echo_clock_inverted = s.cq_n;
    assign bus.read_valid_flag = s.valid;
    assign loop_locked = s.locked;
    assign odt_enable = s.odt_on;
    assign odt_high_range = s.odt_hi;
    assign burst_busy = s.state != DEV_IDLE;

endmodule : dbs_device

// *** verilog/dbs_fifo.sv ***
`timescale 1ns/1ps
module dbs_fifo import dbs_pkg::*; #(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW:0] wp;
        logic [PW:0] rp;
    } dbs_fifo_st_t;

    dbs_fifo_st_t s;
    dbs_fifo_st_t next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // ==========================================================
    // Pointers carry one extra bit so full and empty differ
    assign level = s.wp - s.rp;
    assign in_ready = level != (PW+1)'(DEPTH);
    assign out_valid = s.wp != s.rp;
    assign out_data = mem[s.rp[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wp[PW-1:0]] <= in_data;
        end
    end

endmodule : dbs_fifo

// *** verilog/dbs_host.sv ***
`timescale 1ns/1ps
module dbs_host import dbs_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    dbs_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [LANES-1:0] wr_byte_en_n,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    input wire logic bypass_req_n,
    input wire logic term_sel_req,
    input wire logic term_float_req,
    output logic host_ready
);

    typedef struct packed {
        dbs_host_state_t state;
        logic k;
        logic load_n;
        logic rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic [LANES-1:0] be_n;
        logic [CNT_W-1:0] cnt;
        logic [LOCK_W-1:0] wait_cnt;
        logic valid_d;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic byp_n;
        logic tsel;
        logic tfloat;
    } dbs_host_st_t;

    dbs_host_st_t s;
    dbs_host_st_t next_s;
    logic pop;
    logic [FIFO_W-1:0] pop_data;
    logic pop_valid;
    logic [$clog2(FIFO_DEPTH):0] level;
    logic issue;

    // ==========================================================
    // Write data buffer; a write is issued only once a whole burst waits
    dbs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data({wr_byte_en_n, wr_data}),
        .out_valid(pop_valid),
        .out_ready(pop),
        .out_data(pop_data),
        .level(level)
    );

    // Issue only on a beat whose next edge is a main clock rise
    assign cmd_ready = s.state == HOST_IDLE && !s.k
        && (!cmd_write || level >= ($clog2(FIFO_DEPTH)+1)'(BURST_LEN));
    assign issue = cmd_valid && cmd_ready;
    assign pop = s.state == HOST_BUSY && !s.rw && pop_valid
        && s.cnt >= POP_FIRST && s.cnt <= POP_LAST;

    // ==========================================================
    // Controller sequence
    always_comb begin
        next_s = s;
        // Clocks run from reset and never park
        next_s.k = !s.k;
        next_s.load_n = 1'b1;
        next_s.dq_oe = 1'b0;
        next_s.be_n = BE_NONE_N;
        next_s.valid_d = bus.read_valid_flag;
        next_s.rd_valid = s.valid_d;
        next_s.byp_n = bypass_req_n;
        next_s.tsel = term_sel_req;
        next_s.tfloat = term_float_req;
        if (s.valid_d) begin
            next_s.rd_data = bus.dq;
        end
        if (pop) begin
            next_s.dq = pop_data[DATA_W-1:0];
            next_s.be_n = pop_data[FIFO_W-1:DATA_W];
            next_s.dq_oe = 1'b1;
        end
        case (s.state)
            HOST_START: begin
                if (bypass_req_n != s.byp_n) begin
                    next_s.wait_cnt = '0;
                end else if (s.wait_cnt == LOOP_SETUP_CYC - 1'b1) begin
                    next_s.state = HOST_IDLE;
                end else begin
                    next_s.wait_cnt = s.wait_cnt + 1'b1;
                end
            end
            HOST_IDLE: begin
                if (bypass_req_n != s.byp_n) begin
                    next_s.wait_cnt = '0;
                    next_s.state = HOST_START;
                end else if (issue) begin
                    next_s.load_n = 1'b0;
                    next_s.rw = !cmd_write;
                    next_s.addr = cmd_addr;
                    next_s.cnt = '0;
                    next_s.state = HOST_BUSY;
                end
            end
            HOST_BUSY: begin
                next_s.cnt = s.cnt + 1'b1;
                if (s.cnt == (s.rw ? HOST_RD_DONE : HOST_WR_DONE)) begin
                    next_s.state = HOST_IDLE;
                end
            end
            default: begin
                next_s.state = HOST_START;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '{state: HOST_START, load_n: 1'b1, be_n: BE_NONE_N, byp_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Pins
    assign bus.k = s.k;
    assign bus.k_n = !s.k;
    assign bus.load_cycle_n = s.load_n;
    assign bus.read_write = s.rw;
    assign bus.address_inputs = s.addr;
    assign bus.byte_write_enable_n = s.be_n;
    assign bus.host_dq = s.dq;
    assign bus.host_dq_oe = s.dq_oe;
    assign bus.loop_bypass_n = s.byp_n;
    assign bus.termination_select = s.tsel;
    assign bus.termination_float = s.tfloat;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign host_ready = s.state != HOST_START;

endmodule : dbs_host

// *** verilog/dbs_if.sv ***
`timescale 1ns/1ps
interface dbs_if;
    import dbs_pkg::*;

    logic k;
    logic k_n;
    logic load_cycle_n;
    logic read_write;
    logic [ADDR_W-1:0] address_inputs;
    logic [LANES-1:0] byte_write_enable_n;
    logic [DATA_W-1:0] host_dq;
    logic host_dq_oe;
    logic [DATA_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic [DATA_W-1:0] dq;
    logic echo_clock;
    logic echo_clock_inverted;
    logic read_valid_flag;
    logic loop_bypass_n;
    logic termination_select;
    logic termination_float;

    // Shared bus level; the device has priority when both drive
    assign dq = dev_dq_oe ? dev_dq : host_dq;

    modport device (
        input k, k_n, load_cycle_n, read_write, address_inputs, byte_write_enable_n,
        input dq, loop_bypass_n, termination_select, termination_float,
        output dev_dq, dev_dq_oe, echo_clock, echo_clock_inverted, read_valid_flag
    );

    modport host (
        output k, k_n, load_cycle_n, read_write, address_inputs, byte_write_enable_n,
        output host_dq, host_dq_oe, loop_bypass_n, termination_select, termination_float,
        input dq, echo_clock, echo_clock_inverted, read_valid_flag
    );

endinterface : dbs_if

// *** verilog/dbs_pkg.sv ***
package dbs_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W = 18;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 21;
    localparam int BURST_LEN = 4;
    // Backing array is kept small; upper address bits alias onto it
    localparam int MEM_AW = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = DATA_W + LANES;
    localparam int CNT_W = 4;
    localparam int LOCK_W = 12;

    // ==========================================================
    // Timing, in beats of one clk cycle (two beats per main clock period)
    localparam int CLK_PERIOD_NS = 8;
    localparam int LOOP_SETUP_US = 20;
    localparam int LOOP_SETUP_CYC_I = (LOOP_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [LOCK_W-1:0] LOOP_SETUP_CYC = LOCK_W'(LOOP_SETUP_CYC_I);
    localparam int RD_LAT_BEATS = 5;
    localparam int WR_LAT_BEATS = 2;
    localparam logic [CNT_W-1:0] RD_WAIT_LAST = CNT_W'(RD_LAT_BEATS - 2);
    localparam logic [CNT_W-1:0] WR_WAIT_LAST = CNT_W'(WR_LAT_BEATS - 2);
    localparam logic [CNT_W-1:0] BEAT_LAST = CNT_W'(BURST_LEN - 1);
    localparam logic [CNT_W-1:0] VALID_LAST = CNT_W'(BURST_LEN - 3);
    localparam logic [CNT_W-1:0] POP_FIRST = CNT_W'(WR_LAT_BEATS - 1);
    localparam logic [CNT_W-1:0] POP_LAST = CNT_W'(WR_LAT_BEATS + BURST_LEN - 2);
    localparam logic [CNT_W-1:0] HOST_WR_DONE = CNT_W'(WR_LAT_BEATS + BURST_LEN - 1);
    localparam logic [CNT_W-1:0] HOST_RD_DONE = CNT_W'(RD_LAT_BEATS + BURST_LEN - 1);
    localparam logic [LANES-1:0] BE_NONE_N = {LANES{1'b1}};

    // ==========================================================
    // States
    typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_XFER} dbs_dev_state_t;
    typedef enum logic [1:0] {HOST_START, HOST_IDLE, HOST_BUSY} dbs_host_state_t;

endpackage : dbs_pkg
